// ---- inc/fes_cfg.svh ----
// offsets, field positions and reset values of the framer event status block
// assumes a 16-bit AXI4-Lite byte address; registers sit at index * 4
`ifndef FES_CFG_SVH
`define FES_CFG_SVH

`define FES_ADDR_W        16
`define FES_IDX_W         14
`define FES_STATUS_IDX    14'h0B04
`define FES_ENABLE_IDX    14'h0B05
`define FES_CLEAR_IDX     14'h0B06
`define FES_CONFIG_IDX    14'h0B07
`define FES_STATE_IDX     14'h0B08

`define FES_SIG_BIT       5
`define FES_ALIGN_BIT     4
`define FES_OOF_BIT       3
`define FES_EVT_MASK      8'h38
`define FES_REG_RESET     8'h00

`define FES_TOL_LSB       0
`define FES_TOL_W         4
`define FES_RANGE_LSB     4
`define FES_RANGE_W       4
`define FES_RBS_BIT       8
`define FES_TOL_RESET     4'h2
`define FES_RANGE_RESET   4'h4
`define FES_RBS_RESET     1'h1
`define FES_OOF_BIT_STATE 0

`define FES_T1_CHANNELS   24
`define FES_CHAN_W        5
`define FES_ABCD_W        4

`define FES_RESP_OKAY     2'h0
`define FES_RESP_SLVERR   2'h2

`endif

// ---- inc/fes_pkg.sv ----
// types shared by the framer event status block
// assumes nothing beyond a SystemVerilog compiler
package fes_pkg;

  typedef enum logic {
    IN_FRAME,
    OUT_OF_FRAME
  } sync_state_e;

  typedef logic [7:0] status_t;

endpackage

// ---- inc/sig_mem_if.sv ----
// carrier between the signaling change detector and its channel store
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface sig_mem_if #(
  parameter int AW = 5,
  parameter int DW = 4
) ();
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport user  (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// ---- hdl/sig_store.sv ----
// last signaling nibble of every channel, registered read port
// assumes reads and writes from one clock domain; read is before write
`timescale 1ns/1ps
module sig_store #(
  parameter int DEPTH = 24
) (
  input  wire logic i_ref_clk,
  sig_mem_if.store  mem
);
  logic [$bits(mem.wr_data)-1:0] store_mem [DEPTH];
  logic [$bits(mem.wr_data)-1:0] rd_data_reg;

  // no reset on the array: first sample of a channel is masked upstream
  always_ff @(posedge i_ref_clk) begin
    if (mem.wr_en) begin
      store_mem[mem.wr_addr] <= mem.wr_data;
    end
    if (mem.rd_en) begin
      rd_data_reg <= store_mem[mem.rd_addr];
    end
  end

  assign mem.rd_data = rd_data_reg;
endmodule

// ---- hdl/frame_sync_monitor.sv ----
// out-of-frame declare / clear tracker over back-to-back fixed windows of framing bits
// assumes one pulse per framing bit and an error strobe in the same cycle
`timescale 1ns/1ps
`include "fes_cfg.svh"
module frame_sync_monitor
  import fes_pkg::*;
#(
  parameter int TOL_W   = `FES_TOL_W,
  parameter int RANGE_W = `FES_RANGE_W
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_fbit_tick,
  input  wire logic               i_fbit_err,
  input  wire logic               i_frame_found,
  input  wire logic [TOL_W-1:0]   i_tol,
  input  wire logic [RANGE_W-1:0] i_range,
  output logic                    o_oof,
  output logic                    o_change
);
  sync_state_e        state_reg, state_next;
  logic [RANGE_W-1:0] bit_cnt_reg, bit_cnt_next;
  logic [TOL_W:0]     err_cnt_reg, err_cnt_next;
  logic               change_reg;

  wire [TOL_W:0] err_total  = err_cnt_reg + (TOL_W+1)'(i_fbit_err);
  wire           win_end    = ((RANGE_W+1)'(bit_cnt_reg) + 1'b1) >= (RANGE_W+1)'(i_range);
  // a zero tolerance disables declaration rather than firing every bit
  wire           declare    = i_fbit_tick && (i_tol != '0)
                              && (err_total >= (TOL_W+1)'(i_tol));
  wire           reacquired = i_frame_found;

  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    err_cnt_next = err_cnt_reg;
    case (state_reg)
      IN_FRAME: begin
        if (declare) begin
          state_next   = OUT_OF_FRAME;
          bit_cnt_next = '0;
          err_cnt_next = '0;
        end else if (i_fbit_tick) begin
          bit_cnt_next = win_end ? '0 : bit_cnt_reg + 1'b1;
          err_cnt_next = win_end ? '0 : err_total;
        end
      end
      OUT_OF_FRAME: begin
        if (reacquired) begin
          state_next = IN_FRAME;
        end
      end
      default: begin
        state_next = IN_FRAME;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg   <= IN_FRAME;
      bit_cnt_reg <= '0;
      err_cnt_reg <= '0;
      change_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      err_cnt_reg <= err_cnt_next;
      change_reg  <= state_next != state_reg;
    end
  end

  assign o_oof    = state_reg == OUT_OF_FRAME;
  assign o_change = change_reg;

  property p_oof_declare;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (state_reg == IN_FRAME) && declare |=> o_oof && o_change;
  endproperty
  a_oof_declare: assert property (p_oof_declare) else $error("oof not declared at tolerance");
endmodule

// ---- hdl/t1_framer_event_status.sv ----
// receive framer event status latch with AXI4-Lite register access
// assumes framer strobes are synchronous one-cycle pulses on i_ref_clk
`timescale 1ns/1ps
`include "fes_cfg.svh"

// Overview of operation
// - any A/B/C/D change on any of 24 channels sets signaling flag
// - status bits read 1 if event since last read; read clears them
// - signaling changes are not reported while robbed-bit mode is off
// - framing bits moving position sets frame alignment flag, bit 4
// - out-of-frame declare and clear both set bit 3
// - out-of-frame declared at tolerance errors within programmed bit range
// - status bits 7 and 6 reserved, always zero in T1
// - latched event interrupts only when its enable bit is set
module t1_framer_event_status
  import fes_pkg::*;
#(
  parameter int NUM_CHAN = `FES_T1_CHANNELS,
  parameter int TOL_W    = `FES_TOL_W,
  parameter int RANGE_W  = `FES_RANGE_W
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [`FES_ADDR_W-1:0] i_awaddr,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  output logic [1:0]                  o_bresp,
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  input  wire logic [`FES_ADDR_W-1:0] i_araddr,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic [31:0]                 o_rdata,
  output logic [1:0]                  o_rresp,
  input  wire logic                   i_sig_valid,
  input  wire logic [`FES_CHAN_W-1:0] i_sig_chan,
  input  wire logic [`FES_ABCD_W-1:0] i_sig_abcd,
  input  wire logic                   i_align_moved,
  input  wire logic                   i_fbit_tick,
  input  wire logic                   i_fbit_err,
  input  wire logic                   i_frame_found,
  output logic                        o_irq,
  output logic                        o_oof
);

  //////////////////////////////////////////////////////////////////////////////
  // write channel
  logic                   aw_full_reg, w_full_reg, awready_reg, wready_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic [`FES_IDX_W-1:0]  waddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;

  wire aw_take      = i_awvalid && awready_reg;
  wire w_take       = i_wvalid && wready_reg;
  wire wr_do        = aw_full_reg && w_full_reg && !bvalid_reg;
  wire aw_full_next = (aw_full_reg && !wr_do) || aw_take;
  wire w_full_next  = (w_full_reg && !wr_do) || w_take;
  wire bvalid_next  = wr_do || (bvalid_reg && !i_bready);

  wire w_status = waddr_reg == `FES_STATUS_IDX;
  wire w_enable = waddr_reg == `FES_ENABLE_IDX;
  wire w_clear  = waddr_reg == `FES_CLEAR_IDX;
  wire w_config = waddr_reg == `FES_CONFIG_IDX;
  wire w_state  = waddr_reg == `FES_STATE_IDX;
  wire w_map    = w_status || w_enable || w_clear || w_config || w_state;

  wire wr_enable = wr_do && w_enable && wstrb_reg[0];
  wire wr_clear  = wr_do && w_clear && wstrb_reg[0];
  wire wr_cfg_lo = wr_do && w_config && wstrb_reg[0];
  wire wr_cfg_hi = wr_do && w_config && wstrb_reg[1];

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `FES_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg  <= !w_full_next;
      bvalid_reg  <= bvalid_next;
      if (wr_do) begin
        bresp_reg <= w_map ? `FES_RESP_OKAY : `FES_RESP_SLVERR;
      end
    end
  end

  // payload holders carry no control meaning, so no reset needed
  always_ff @(posedge i_ref_clk) begin
    if (aw_take) begin
      waddr_reg <= i_awaddr[`FES_ADDR_W-1:2];
    end
    if (w_take) begin
      wdata_reg <= i_wdata;
      wstrb_reg <= i_wstrb;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  status_t            enable_reg, enable_next;
  logic [TOL_W-1:0]   cfg_tol_reg;
  logic [RANGE_W-1:0] cfg_range_reg;
  logic               rbs_en_reg;

  assign enable_next = wr_enable ? (wdata_reg[7:0] & `FES_EVT_MASK) : enable_reg;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      enable_reg    <= `FES_REG_RESET;
      cfg_tol_reg   <= `FES_TOL_RESET;
      cfg_range_reg <= `FES_RANGE_RESET;
      rbs_en_reg    <= `FES_RBS_RESET;
    end else begin
      enable_reg <= enable_next;
      if (wr_cfg_lo) begin
        cfg_tol_reg   <= wdata_reg[`FES_TOL_LSB +: TOL_W];
        cfg_range_reg <= wdata_reg[`FES_RANGE_LSB +: RANGE_W];
      end
      if (wr_cfg_hi) begin
        rbs_en_reg <= wdata_reg[`FES_RBS_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // signaling change detection
  sig_mem_if #(.AW(`FES_CHAN_W), .DW(`FES_ABCD_W)) sig_mem ();

  logic                   p_valid_reg, fwd_reg;
  logic [`FES_CHAN_W-1:0] p_chan_reg;
  logic [`FES_ABCD_W-1:0] p_abcd_reg, fwd_data_reg;
  logic [NUM_CHAN-1:0]    seen_reg;

  wire chan_ok = 32'(i_sig_chan) < NUM_CHAN;
  wire lookup  = i_sig_valid && chan_ok;
  // same channel back to back: the store still returns the older nibble
  wire fwd_hit = lookup && p_valid_reg && (i_sig_chan == p_chan_reg);
  wire [`FES_ABCD_W-1:0] prev_abcd = fwd_reg ? fwd_data_reg : sig_mem.rd_data;
  wire seen_hit = seen_reg[p_chan_reg];
  wire sig_diff = p_valid_reg && seen_hit && (prev_abcd != p_abcd_reg);
  wire sig_evt  = sig_diff && rbs_en_reg;

  assign sig_mem.rd_en   = lookup;
  assign sig_mem.rd_addr = i_sig_chan;
  assign sig_mem.wr_en   = p_valid_reg;
  assign sig_mem.wr_addr = p_chan_reg;
  assign sig_mem.wr_data = p_abcd_reg;

  sig_store #(.DEPTH(NUM_CHAN)) u_sig_store (
    .i_ref_clk (i_ref_clk),
    .mem       (sig_mem.store)
  );

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      p_valid_reg <= 1'b0;
      fwd_reg     <= 1'b0;
      seen_reg    <= '0;
    end else begin
      p_valid_reg <= lookup;
      fwd_reg     <= fwd_hit;
      if (p_valid_reg) begin
        seen_reg[p_chan_reg] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    p_chan_reg   <= i_sig_chan;
    p_abcd_reg   <= i_sig_abcd;
    fwd_data_reg <= p_abcd_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // out-of-frame tracking
  logic oof_state, oof_evt, oof_reg;

  frame_sync_monitor #(.TOL_W(TOL_W), .RANGE_W(RANGE_W)) u_sync (
    .i_ref_clk     (i_ref_clk),
    .i_rstn        (i_rstn),
    .i_fbit_tick   (i_fbit_tick),
    .i_fbit_err    (i_fbit_err),
    .i_frame_found (i_frame_found),
    .i_tol         (cfg_tol_reg),
    .i_range       (cfg_range_reg),
    .o_oof         (oof_state),
    .o_change      (oof_evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read channel and status latch
  logic  arready_reg, rvalid_reg, irq_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  status_t     status_reg, status_next, evt_set, clr_mask;

  wire ar_take    = i_arvalid && arready_reg;
  wire rvalid_nxt = ar_take || (rvalid_reg && !i_rready);
  wire [`FES_IDX_W-1:0] r_idx = i_araddr[`FES_ADDR_W-1:2];
  wire r_status = r_idx == `FES_STATUS_IDX;
  wire r_enable = r_idx == `FES_ENABLE_IDX;
  wire r_clear  = r_idx == `FES_CLEAR_IDX;
  wire r_config = r_idx == `FES_CONFIG_IDX;
  wire r_state  = r_idx == `FES_STATE_IDX;
  wire r_map    = r_status || r_enable || r_clear || r_config || r_state;
  wire rd_status = ar_take && r_status;

  wire [31:0] cfg_word = (32'(cfg_tol_reg) << `FES_TOL_LSB)
                       | (32'(cfg_range_reg) << `FES_RANGE_LSB)
                       | (32'(rbs_en_reg) << `FES_RBS_BIT);
  wire [31:0] rd_word  = r_status ? 32'(status_reg)
                       : r_enable ? 32'(enable_reg)
                       : r_config ? cfg_word
                       : r_state  ? (32'(oof_reg) << `FES_OOF_BIT_STATE)
                       : 32'h0000_0000;

  assign evt_set = (8'(sig_evt) << `FES_SIG_BIT)
                 | (8'(i_align_moved) << `FES_ALIGN_BIT)
                 | (8'(oof_evt) << `FES_OOF_BIT);
  assign clr_mask = (rd_status ? `FES_EVT_MASK : `FES_REG_RESET)
                  | (wr_clear ? wdata_reg[7:0] : `FES_REG_RESET);
  // new events win over a read or write clear in the same cycle
  assign status_next = ((status_reg & ~clr_mask) | evt_set) & `FES_EVT_MASK;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `FES_RESP_OKAY;
      status_reg  <= `FES_REG_RESET;
      irq_reg     <= 1'b0;
      oof_reg     <= 1'b0;
    end else begin
      arready_reg <= !rvalid_nxt;
      rvalid_reg  <= rvalid_nxt;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= r_map ? `FES_RESP_OKAY : `FES_RESP_SLVERR;
      end
      status_reg <= status_next;
      irq_reg    <= |(status_next & enable_next);
      oof_reg    <= oof_state;
    end
  end

  assign o_awready = awready_reg;
  assign o_wready  = wready_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rdata   = rdata_reg;
  assign o_rresp   = rresp_reg;
  assign o_irq     = irq_reg;
  assign o_oof     = oof_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  property p_sig_sets;
    p_valid_reg && seen_hit && (prev_abcd != p_abcd_reg) && rbs_en_reg
      |=> status_reg[`FES_SIG_BIT];
  endproperty
  a_sig_sets: assert property (p_sig_sets) else $error("signaling change lost");

  property p_rbs_off;
    !rbs_en_reg && !status_reg[`FES_SIG_BIT] |=> !status_reg[`FES_SIG_BIT];
  endproperty
  a_rbs_off: assert property (p_rbs_off) else $error("signaling flag set in rbs off");

  property p_align_sets;
    i_align_moved |=> status_reg[`FES_ALIGN_BIT];
  endproperty
  a_align_sets: assert property (p_align_sets) else $error("alignment move lost");

  property p_oof_both_edges;
    $changed(oof_state) |-> ##1 status_reg[`FES_OOF_BIT] && (o_oof == $past(oof_state));
  endproperty
  a_oof_both_edges: assert property (p_oof_both_edges) else $error("oof change lost");

  property p_read_clears;
    rd_status && (evt_set == `FES_REG_RESET)
      |=> (status_reg == `FES_REG_RESET) && o_rvalid && (o_rdata[7:0] == $past(status_reg));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

  property p_reserved;
    o_rvalid && (o_rdata[7:0] == status_reg) |-> !status_reg[7] && !status_reg[6];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");

  property p_masked;
    ((status_reg & enable_reg) == `FES_REG_RESET) |-> !o_irq;
  endproperty
  a_masked: assert property (p_masked) else $error("irq without enabled status");

  property p_irq_level;
    |(status_reg & enable_reg) |-> o_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq low with enabled status");

  c_sig_irq:  cover property (sig_evt && enable_reg[`FES_SIG_BIT] ##1 o_irq);
  c_oof_trip: cover property ($rose(oof_state) ##[1:200] $fell(oof_state));
  c_set_clr:  cover property (rd_status && (evt_set != `FES_REG_RESET));
endmodule

// ---- test/t1_framer_event_status_test.sv ----
// self-checking bench for the framer event status latch
// assumes the design files and fes_cfg.svh are on the include path
`timescale 1ns/1ps
`include "fes_cfg.svh"
module t1_framer_event_status_test
  import fes_pkg::*;
;
  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] chan;
    logic [3:0] abcd;
    status_t    en;
    status_t    st;
    logic       irq;
    logic       oof;
  } row_s;

  localparam logic [15:0] A_STAT  = {`FES_STATUS_IDX, 2'h0};
  localparam logic [15:0] A_EN    = {`FES_ENABLE_IDX, 2'h0};
  localparam logic [15:0] A_CLR   = {`FES_CLEAR_IDX, 2'h0};
  localparam logic [15:0] A_CFG   = {`FES_CONFIG_IDX, 2'h0};
  localparam logic [15:0] A_STATE = {`FES_STATE_IDX, 2'h0};
  localparam logic [1:0]  OK      = `FES_RESP_OKAY;

  // kind: 0 alignment, 1 signaling, 2 two framing errors, 3 frame found
  row_s rows [0:10] = '{
    '{2'h0, 5'h00, 4'h0, 8'h00, 8'h10, 1'h0, 1'h0},
    '{2'h0, 5'h00, 4'h0, 8'h10, 8'h10, 1'h1, 1'h0},
    '{2'h0, 5'h00, 4'h0, 8'h28, 8'h10, 1'h0, 1'h0},
    '{2'h1, 5'h00, 4'h5, 8'h20, 8'h20, 1'h1, 1'h0},
    '{2'h1, 5'h00, 4'h5, 8'h20, 8'h00, 1'h0, 1'h0},
    '{2'h1, 5'h17, 4'hA, 8'h38, 8'h20, 1'h1, 1'h0},
    '{2'h1, 5'h18, 4'hF, 8'h20, 8'h00, 1'h0, 1'h0},
    '{2'h2, 5'h00, 4'h0, 8'h08, 8'h08, 1'h1, 1'h1},
    '{2'h3, 5'h00, 4'h0, 8'h08, 8'h08, 1'h1, 1'h0},
    '{2'h2, 5'h00, 4'h0, 8'h30, 8'h08, 1'h0, 1'h1},
    '{2'h3, 5'h00, 4'h0, 8'h00, 8'h08, 1'h0, 1'h0}
  };

  logic        ref_clk;
  logic        rstn;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        sig_valid, align_moved, fbit_tick, fbit_err, frame_found;
  logic [4:0]  sig_chan;
  logic [3:0]  sig_abcd;
  logic        irq, oof;
  int          err_count;
  int          checks;

  t1_framer_event_status t1_framer_event_status_i (
    .i_ref_clk(ref_clk), .i_rstn(rstn),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_sig_valid(sig_valid), .i_sig_chan(sig_chan), .i_sig_abcd(sig_abcd),
    .i_align_moved(align_moved), .i_fbit_tick(fbit_tick), .i_fbit_err(fbit_err),
    .i_frame_found(frame_found), .o_irq(irq), .o_oof(oof)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // fresh edge first so no signal gets two assignments in one time step
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  task automatic pulse(input logic [1:0] k, input logic [4:0] c, input logic [3:0] v);
    @(posedge ref_clk);
    align_moved <= (k == 2'h0);
    sig_valid <= (k == 2'h1);
    frame_found <= (k == 2'h3);
    sig_chan <= c;
    sig_abcd <= v;
    @(posedge ref_clk);
    align_moved <= 1'b0;
    sig_valid <= 1'b0;
    frame_found <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // bit i of pat marks framing bit i as errored
  task automatic fbits(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      fbit_tick <= 1'b1;
      fbit_err <= pat[i];
    end
    @(posedge ref_clk);
    fbit_tick <= 1'b0;
    fbit_err <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    err_count = 0;
    checks = 0;
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {sig_valid, align_moved, fbit_tick, fbit_err, frame_found} = 5'h0;
    awaddr = 16'h0;
    araddr = 16'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    sig_chan = 5'h0;
    sig_abcd = 4'h0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    rd(A_STAT, 32'h0, OK);
    rd(A_EN, 32'h0, OK);
    rd(A_CFG, 32'h142, OK);
    rd(A_STATE, 32'h0, OK);
    // first nibble of a channel only seeds the store
    pulse(2'h1, 5'h00, 4'h0);
    pulse(2'h1, 5'h17, 4'h0);
    rd(A_STAT, 32'h0, OK);
    for (int k = 0; k < 11; k++) begin
      wr(A_EN, {24'h0, rows[k].en}, OK);
      if (rows[k].kind == 2'h2) begin
        fbits(8'h03, 2);
      end else begin
        pulse(rows[k].kind, rows[k].chan, rows[k].abcd);
      end
      chk(32'(irq), 32'(rows[k].irq));
      chk(32'(oof), 32'(rows[k].oof));
      rd(A_STAT, 32'(rows[k].st), OK);
      rd(A_STAT, 32'h0, OK);
      chk(32'(irq), 32'h0);
    end
    wr(A_EN, 32'hFFFF_FFFF, OK);
    rd(A_EN, 32'h38, OK);
    pulse(2'h0, 5'h00, 4'h0);
    chk(32'(irq), 32'h1);
    wr(A_STAT, 32'h0, OK);
    rd(A_STAT, 32'h10, OK);
    pulse(2'h0, 5'h00, 4'h0);
    wr(A_CLR, 32'h10, OK);
    chk(32'(irq), 32'h0);
    rd(A_STAT, 32'h0, OK);
    // robbed-bit mode off: nibble stored, nothing flagged
    wr(A_CFG, 32'h042, OK);
    pulse(2'h1, 5'h00, 4'h9);
    rd(A_STAT, 32'h0, OK);
    wr(A_CFG, 32'h142, OK);
    pulse(2'h1, 5'h00, 4'h9);
    rd(A_STAT, 32'h0, OK);
    pulse(2'h1, 5'h00, 4'h6);
    rd(A_STAT, 32'h20, OK);
    // tolerance 3 in a window of 4: 1,0,0,1,1 spans five bits, 1,0,1,1 four
    wr(A_CFG, 32'h143, OK);
    fbits(8'h00, 4);
    fbits(8'h19, 5);
    chk(32'(oof), 32'h0);
    rd(A_STAT, 32'h0, OK);
    // windows run back to back: one bit of the last window is open, three close it
    fbits(8'h00, 3);
    fbits(8'h0D, 4);
    chk(32'(oof), 32'h1);
    rd(A_STAT, 32'h08, OK);
    rd(A_STATE, 32'h1, OK);
    pulse(2'h3, 5'h00, 4'h0);
    rd(A_STATE, 32'h0, OK);
    rd(A_STAT, 32'h08, OK);
    rd(16'h3000, 32'h0, `FES_RESP_SLVERR);
    wr(16'h3000, 32'h0, `FES_RESP_SLVERR);
    // reset in mid-run drops a pending interrupt
    wr(A_EN, 32'h10, OK);
    pulse(2'h0, 5'h00, 4'h0);
    chk(32'(irq), 32'h1);
    rstn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(A_STAT, 32'h0, OK);
    rd(A_EN, 32'h0, OK);
    stop_test();
  end
endmodule
